// >>> include/aclk_defs.svh
// constants of the serial audio codec link
`ifndef ACLK_DEFS_SVH
`define ACLK_DEFS_SVH

// ==========================================================
// clocking
`define ACLK_SYS_CLK_MHZ 20
`define ACLK_XTAL_KHZ 24576
`define ACLK_BCLK_KHZ 12288
`define ACLK_BCLK_DIV (`ACLK_XTAL_KHZ / `ACLK_BCLK_KHZ)
`define ACLK_BCLK_HALF_CYC 4'h8

// ==========================================================
// frame timing in bit-clock periods, frame rate in kHz, field widths in bits
`define ACLK_FRAME_RATE_KHZ 48
`define ACLK_FRAME_LAST 8'hff
`define ACLK_MARK_LEN 8'h10
`define ACLK_PAY_LAST 8'h5f
`define ACLK_HOST_RX_LAST 8'h61
`define ACLK_PAY_W 96
`define ACLK_SLOT_W 20
`define ACLK_SAMPLE_W 18

// ==========================================================
// tag bits, and the read bit of the address slot
`define ACLK_TAG_FRAME 15
`define ACLK_TAG_CMD_ADDR 14
`define ACLK_TAG_CMD_DATA 13
`define ACLK_TAG_LEFT 12
`define ACLK_TAG_RIGHT 11
`define ACLK_ADDR_READ 19

// ==========================================================
// codec control registers
`define ACLK_REG_N 16
`define ACLK_REG_PWR 4'h6
`define ACLK_PWR_LINK_BIT 12
`define ACLK_REG_TEST 4'hf
`define ACLK_TEST_ATE_BIT 0
`define ACLK_TEST_VENDOR_BIT 1
`define ACLK_REG_RESET 16'h0000

// ==========================================================
// reset pulse lengths
`define ACLK_COLD_HOLD_NS 1000
`define ACLK_COLD_HOLD_CYC ((`ACLK_COLD_HOLD_NS * `ACLK_SYS_CLK_MHZ + 999) / 1000)
`define ACLK_WARM_HOLD_NS 1000
`define ACLK_WARM_HOLD_CYC ((`ACLK_WARM_HOLD_NS * `ACLK_SYS_CLK_MHZ + 999) / 1000)

`endif

// >>> include/aclk_pkg.sv
// types and frame helpers of the serial audio codec link
`default_nettype none
`include "aclk_defs.svh"
package aclk_pkg;

   // ==========================================================
   // states
   typedef enum logic [2:0] {
      aclk_c_off = 3'h1,
      aclk_c_run = 3'h2,
      aclk_c_pdown = 3'h4
   } aclk_codec_st_t;

   typedef enum logic [2:0] {
      aclk_h_cold = 3'h1,
      aclk_h_run = 3'h2,
      aclk_h_warm = 3'h4
   } aclk_host_st_t;

   // ==========================================================
   // module state
   typedef struct packed {
      logic ff1;
      logic ff2;
      logic ff3;
   } aclk_sync_s_t;

   typedef struct packed {
      aclk_codec_st_t st;
      logic [3:0] div;
      logic bclk;
      logic in_frame;
      logic [7:0] cnt;
      logic [`ACLK_PAY_W-1:0] tx_sh;
      logic [`ACLK_PAY_W-1:0] rx_sh;
      logic sdi;
      logic [`ACLK_REG_N-1:0][15:0] regs;
      logic rd_pend;
      logic [6:0] rd_idx;
      logic [`ACLK_SAMPLE_W-1:0] line_l;
      logic [`ACLK_SAMPLE_W-1:0] line_r;
      logic play_stb;
      logic primary;
   } aclk_codec_s_t;

   typedef struct packed {
      aclk_host_st_t st;
      logic [7:0] hold;
      logic cold_n;
      logic mark;
      logic sdo;
      logic [7:0] cnt;
      logic [`ACLK_PAY_W-1:0] tx_sh;
      logic [`ACLK_PAY_W-1:0] rx_sh;
      logic cmd_pend;
      logic cmd_rd;
      logic [6:0] cmd_idx;
      logic [15:0] cmd_wd;
      logic play_pend;
      logic [`ACLK_SAMPLE_W-1:0] play_l;
      logic [`ACLK_SAMPLE_W-1:0] play_r;
      logic [6:0] stat_idx;
      logic [15:0] stat_data;
      logic stat_stb;
      logic [`ACLK_SAMPLE_W-1:0] rec_l;
      logic [`ACLK_SAMPLE_W-1:0] rec_r;
      logic rec_stb_l;
      logic rec_stb_r;
   } aclk_host_s_t;

   // ==========================================================
   // frame layout: tag then four slots, msb first
   function automatic logic [`ACLK_PAY_W-1:0] aclk_pack(
      input logic [15:0] tag,
      input logic [`ACLK_SLOT_W-1:0] s1,
      input logic [`ACLK_SLOT_W-1:0] s2,
      input logic [`ACLK_SLOT_W-1:0] s3,
      input logic [`ACLK_SLOT_W-1:0] s4);
      return {tag, s1, s2, s3, s4};
   endfunction

   function automatic logic [`ACLK_SLOT_W-1:0] aclk_slot(
      input logic [`ACLK_PAY_W-1:0] p,
      input int n);
      return p[(4 - n) * `ACLK_SLOT_W +: `ACLK_SLOT_W];
   endfunction

   function automatic logic [15:0] aclk_tag(input logic [`ACLK_PAY_W-1:0] p);
      return p[`ACLK_PAY_W-1 -: 16];
   endfunction

endpackage
`default_nettype wire

// >>> include/aclk_link_if.sv
// link wires between codec end and host end
`timescale 1ns/10ps
`default_nettype none
interface aclk_link_if;
   logic link_bit_clock;
   logic codec_to_host_serial;
   logic host_to_codec_serial;
   logic frame_marker;
   logic cold_reset_n;

   modport codec (
      output link_bit_clock,
      output codec_to_host_serial,
      input host_to_codec_serial,
      input frame_marker,
      input cold_reset_n
   );

   modport host (
      input link_bit_clock,
      input codec_to_host_serial,
      output host_to_codec_serial,
      output frame_marker,
      output cold_reset_n
   );
endinterface
`default_nettype wire

// >>> hw/aclk_edge_sync.sv
// two-stage synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module aclk_edge_sync (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic pin_in,
   output logic level,
   output logic rise,
   output logic fall
);
   aclk_pkg::aclk_sync_s_t s_reg;
   aclk_pkg::aclk_sync_s_t s_next;

   always_comb begin
      s_next.ff1 = pin_in;
      s_next.ff2 = s_reg.ff1;
      s_next.ff3 = s_reg.ff2;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // ff1 feeds only ff2; edges come from the settled stages
   assign level = s_reg.ff2;
   assign rise = s_reg.ff2 & ~s_reg.ff3;
   assign fall = ~s_reg.ff2 & s_reg.ff3;
endmodule
`default_nettype wire

// >>> hw/aclk_codec_end.sv
// codec end of the serial audio link
//
// How it works
// - codec divides its clock into bit clock
// - codec output bits change on rising edge
// - host bits sampled on falling edge
// - every frame spans 256 bit clocks
// - host marker high 16 of 256
// - first high marker sample starts frame
// - marker within 255 periods is ignored
// - marker high wakes powered-down link
// - cold reset restores registers and state
// - host pulses cold reset before use
// - cold reset leaves both test modes
// - during cold reset beep feeds line out
// - strapped id zero makes primary codec
// - 18-bit samples, independent record/playback valid
`timescale 1ns/10ps
`default_nettype none
`include "aclk_defs.svh"
module aclk_codec_end (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   aclk_link_if.codec link,
   input wire logic codec_id_strap_high,
   input wire logic codec_id_strap_low,
   input wire logic [`ACLK_SAMPLE_W-1:0] beep_mono_input,
   input wire logic [`ACLK_SAMPLE_W-1:0] rec_left,
   input wire logic [`ACLK_SAMPLE_W-1:0] rec_right,
   input wire logic rec_valid_left,
   input wire logic rec_valid_right,
   output logic [`ACLK_SAMPLE_W-1:0] line_out_left,
   output logic [`ACLK_SAMPLE_W-1:0] line_out_right,
   output logic play_strobe,
   output logic test_ate,
   output logic test_vendor,
   output logic link_powered_down,
   output logic primary_codec
);
   // ==========================================================
   // pin synchronisers
   localparam int NPIN = 5;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_lvl;
   logic fm_lvl;
   logic sdo_lvl;
   logic cold_lvl_n;
   logic strap_hi;
   logic strap_lo;

   assign pin_raw = {codec_id_strap_low, codec_id_strap_high, link.cold_reset_n,
                     link.host_to_codec_serial, link.frame_marker};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
         aclk_edge_sync u_sync (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ce(ce),
            .pin_in(pin_raw[gi]),
            .level(pin_lvl[gi]),
            .rise(),
            .fall()
         );
      end
   endgenerate

   assign fm_lvl = pin_lvl[0];
   assign sdo_lvl = pin_lvl[1];
   assign cold_lvl_n = pin_lvl[2];
   assign strap_hi = pin_lvl[3];
   assign strap_lo = pin_lvl[4];

   // ==========================================================
   // state
   aclk_pkg::aclk_codec_s_t s_reg;
   aclk_pkg::aclk_codec_s_t s_next;

   logic bclk_rise;
   logic bclk_fall;
   logic frame_go;
   logic [`ACLK_PAY_W-1:0] tx_word;
   logic [`ACLK_PAY_W-1:0] rx_word;
   logic [15:0] rx_tag;
   logic [15:0] tx_tag;
   logic [`ACLK_SLOT_W-1:0] rx_addr;

   always_comb begin
      s_next = s_reg;
      s_next.play_stb = 1'b0;
      bclk_rise = 1'b0;
      bclk_fall = 1'b0;
      frame_go = 1'b0;
      rx_word = {s_reg.rx_sh[`ACLK_PAY_W-2:0], sdo_lvl};
      rx_tag = aclk_pkg::aclk_tag(rx_word);
      rx_addr = aclk_pkg::aclk_slot(rx_word, 1);

      // record slots valid independently per channel
      tx_tag = 16'h0000;
      tx_tag[`ACLK_TAG_FRAME] = 1'b1;
      tx_tag[`ACLK_TAG_CMD_ADDR] = s_reg.rd_pend;
      tx_tag[`ACLK_TAG_CMD_DATA] = s_reg.rd_pend;
      tx_tag[`ACLK_TAG_LEFT] = rec_valid_left;
      tx_tag[`ACLK_TAG_RIGHT] = rec_valid_right;
      tx_word = aclk_pkg::aclk_pack(tx_tag,
                                    {1'b0, s_reg.rd_idx, 12'h000},
                                    {s_reg.regs[s_reg.rd_idx[3:0]], 4'h0},
                                    {rec_left, 2'b00},
                                    {rec_right, 2'b00});

      // straps read while held in cold reset
      if (!cold_lvl_n) begin
         s_next.primary = ~strap_hi & ~strap_lo;
      end

      case (s_reg.st)
         aclk_pkg::aclk_c_off: begin
            s_next.bclk = 1'b0;
            s_next.div = 4'h0;
            if (cold_lvl_n && s_reg.primary) begin
               s_next.st = aclk_pkg::aclk_c_run;
            end
         end
         aclk_pkg::aclk_c_run: begin
            // bit clock divided from own clock
            if (s_reg.div == 4'(`ACLK_BCLK_HALF_CYC - 4'h1)) begin
               s_next.div = 4'h0;
               s_next.bclk = ~s_reg.bclk;
               bclk_rise = ~s_reg.bclk;
               bclk_fall = s_reg.bclk;
            end else begin
               s_next.div = s_reg.div + 4'h1;
            end

            if (bclk_rise) begin
               // first high marker sample starts frame
               // marker ignored until 255 periods elapsed
               frame_go = fm_lvl && (!s_reg.in_frame || s_reg.cnt == `ACLK_FRAME_LAST);
               if (frame_go) begin
                  s_next.in_frame = 1'b1;
                  s_next.cnt = 8'h00;
                  s_next.sdi = tx_word[`ACLK_PAY_W-1];
                  s_next.tx_sh = {tx_word[`ACLK_PAY_W-2:0], 1'b0};
                  s_next.rd_pend = 1'b0;
               end else if (s_reg.in_frame) begin
                  s_next.sdi = s_reg.tx_sh[`ACLK_PAY_W-1];
                  s_next.tx_sh = {s_reg.tx_sh[`ACLK_PAY_W-2:0], 1'b0};
                  if (s_reg.cnt == `ACLK_FRAME_LAST) begin
                     s_next.in_frame = 1'b0;
                     s_next.cnt = 8'h00;
                  end else begin
                     s_next.cnt = s_reg.cnt + 8'h01;
                  end
               end
            end

            // host data taken on falling edge
            if (bclk_fall && s_reg.in_frame && s_reg.cnt <= `ACLK_PAY_LAST) begin
               s_next.rx_sh = rx_word;
               if (s_reg.cnt == `ACLK_PAY_LAST && rx_tag[`ACLK_TAG_FRAME]) begin
                  if (rx_tag[`ACLK_TAG_CMD_ADDR]) begin
                     if (rx_addr[`ACLK_ADDR_READ]) begin
                        s_next.rd_pend = 1'b1;
                        s_next.rd_idx = rx_addr[18:12];
                     end else if (rx_tag[`ACLK_TAG_CMD_DATA]) begin
                        s_next.regs[rx_addr[15:12]] = 16'(aclk_pkg::aclk_slot(rx_word, 2) >> 4);
                     end
                  end
                  if (rx_tag[`ACLK_TAG_LEFT]) begin
                     s_next.line_l = 18'(aclk_pkg::aclk_slot(rx_word, 3) >> 2);
                     s_next.play_stb = 1'b1;
                  end
                  if (rx_tag[`ACLK_TAG_RIGHT]) begin
                     s_next.line_r = 18'(aclk_pkg::aclk_slot(rx_word, 4) >> 2);
                     s_next.play_stb = 1'b1;
                  end
               end
            end

            // power-down stops the bit clock at once
            if (s_reg.regs[`ACLK_REG_PWR][`ACLK_PWR_LINK_BIT]) begin
               s_next.st = aclk_pkg::aclk_c_pdown;
               s_next.bclk = 1'b0;
               s_next.div = 4'h0;
               s_next.in_frame = 1'b0;
               s_next.cnt = 8'h00;
               s_next.sdi = 1'b0;
            end
         end
         aclk_pkg::aclk_c_pdown: begin
            s_next.bclk = 1'b0;
            // marker level wakes the link, no bit clock needed
            if (fm_lvl) begin
               s_next.regs[`ACLK_REG_PWR][`ACLK_PWR_LINK_BIT] = 1'b0;
               s_next.st = aclk_pkg::aclk_c_run;
            end
         end
         default: begin
            s_next.st = aclk_pkg::aclk_c_off;
         end
      endcase

      // cold reset returns registers and circuits to default
      // test mode bits cleared with the registers
      if (!cold_lvl_n) begin
         s_next.st = aclk_pkg::aclk_c_off;
         s_next.regs = {`ACLK_REG_N{`ACLK_REG_RESET}};
         s_next.bclk = 1'b0;
         s_next.div = 4'h0;
         s_next.in_frame = 1'b0;
         s_next.cnt = 8'h00;
         s_next.tx_sh = '0;
         s_next.rx_sh = '0;
         s_next.sdi = 1'b0;
         s_next.rd_pend = 1'b0;
         s_next.rd_idx = 7'h00;
         // beep routed to both line outputs
         s_next.line_l = beep_mono_input;
         s_next.line_r = beep_mono_input;
         s_next.play_stb = 1'b0;
      end
   end

   // sync reset only; cold reset from the host does the rest
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.st <= aclk_pkg::aclk_c_off;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs
   assign link.link_bit_clock = s_reg.bclk;
   assign link.codec_to_host_serial = s_reg.sdi;
   assign line_out_left = s_reg.line_l;
   assign line_out_right = s_reg.line_r;
   assign play_strobe = s_reg.play_stb;
   assign test_ate = s_reg.regs[`ACLK_REG_TEST][`ACLK_TEST_ATE_BIT];
   assign test_vendor = s_reg.regs[`ACLK_REG_TEST][`ACLK_TEST_VENDOR_BIT];
   assign link_powered_down = (s_reg.st == aclk_pkg::aclk_c_pdown);
   assign primary_codec = s_reg.primary;
endmodule
`default_nettype wire

// >>> hw/aclk_host_end.sv
// host end of the serial audio link
`timescale 1ns/10ps
`default_nettype none
`include "aclk_defs.svh"
module aclk_host_end (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   aclk_link_if.host link,
   input wire logic cold_req,
   input wire logic warm_req,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic [6:0] cmd_index,
   input wire logic [15:0] cmd_wdata,
   input wire logic play_valid,
   output logic play_ready,
   input wire logic [`ACLK_SAMPLE_W-1:0] play_left,
   input wire logic [`ACLK_SAMPLE_W-1:0] play_right,
   output logic [6:0] status_index,
   output logic [15:0] status_data,
   output logic status_strobe,
   output logic [`ACLK_SAMPLE_W-1:0] rec_left,
   output logic [`ACLK_SAMPLE_W-1:0] rec_right,
   output logic rec_strobe_left,
   output logic rec_strobe_right,
   output logic link_running
);
   // ==========================================================
   // synchronisers for bit clock and codec data
   logic bclk_rise;
   logic bclk_fall;
   logic sdi_lvl;

   aclk_edge_sync u_bclk (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ce(ce),
      .pin_in(link.link_bit_clock),
      .level(),
      .rise(bclk_rise),
      .fall(bclk_fall)
   );

   aclk_edge_sync u_sdi (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ce(ce),
      .pin_in(link.codec_to_host_serial),
      .level(sdi_lvl),
      .rise(),
      .fall()
   );

   // ==========================================================
   // state
   aclk_pkg::aclk_host_s_t s_reg;
   aclk_pkg::aclk_host_s_t s_next;
   logic [15:0] tx_tag;
   logic [15:0] rx_tag;
   logic [`ACLK_PAY_W-1:0] tx_word;
   logic [`ACLK_PAY_W-1:0] rx_word;

   assign cmd_ready = ~s_reg.cmd_pend & (s_reg.st == aclk_pkg::aclk_h_run);
   assign play_ready = ~s_reg.play_pend & (s_reg.st == aclk_pkg::aclk_h_run);

   always_comb begin
      s_next = s_reg;
      s_next.stat_stb = 1'b0;
      s_next.rec_stb_l = 1'b0;
      s_next.rec_stb_r = 1'b0;
      tx_tag = 16'h0000;
      tx_tag[`ACLK_TAG_FRAME] = 1'b1;
      tx_tag[`ACLK_TAG_CMD_ADDR] = s_reg.cmd_pend;
      tx_tag[`ACLK_TAG_CMD_DATA] = s_reg.cmd_pend & ~s_reg.cmd_rd;
      tx_tag[`ACLK_TAG_LEFT] = s_reg.play_pend;
      tx_tag[`ACLK_TAG_RIGHT] = s_reg.play_pend;
      tx_word = aclk_pkg::aclk_pack(tx_tag,
                                    {s_reg.cmd_rd, s_reg.cmd_idx, 12'h000},
                                    {s_reg.cmd_wd, 4'h0},
                                    {s_reg.play_l, 2'b00},
                                    {s_reg.play_r, 2'b00});
      rx_word = {s_reg.rx_sh[`ACLK_PAY_W-2:0], sdi_lvl};
      rx_tag = aclk_pkg::aclk_tag(rx_word);

      case (s_reg.st)
         aclk_pkg::aclk_h_cold: begin
            // cold reset held low before link use
            s_next.cold_n = 1'b0;
            s_next.mark = 1'b0;
            s_next.sdo = 1'b0;
            s_next.cnt = 8'h00;
            if (s_reg.hold == 8'(`ACLK_COLD_HOLD_CYC - 1)) begin
               s_next.hold = 8'h00;
               s_next.cold_n = 1'b1;
               s_next.st = aclk_pkg::aclk_h_run;
            end else begin
               s_next.hold = s_reg.hold + 8'h01;
            end
         end
         aclk_pkg::aclk_h_run: begin
            // all timing from detected codec clock edges
            if (bclk_rise) begin
               // marker high for first 16 of 256
               s_next.mark = (s_reg.cnt < `ACLK_MARK_LEN);
               s_next.cnt = s_reg.cnt + 8'h01;
               if (s_reg.cnt == 8'h00) begin
                  s_next.tx_sh = tx_word;
                  s_next.sdo = 1'b0;
                  s_next.cmd_pend = 1'b0;
                  s_next.play_pend = 1'b0;
               end else begin
                  // change on rise, stable at codec fall
                  s_next.sdo = s_reg.tx_sh[`ACLK_PAY_W-1];
                  s_next.tx_sh = {s_reg.tx_sh[`ACLK_PAY_W-2:0], 1'b0};
               end
            end
            // codec bits taken on falling edge
            if (bclk_fall && s_reg.cnt != 8'h00 && s_reg.cnt <= `ACLK_HOST_RX_LAST) begin
               s_next.rx_sh = rx_word;
               if (s_reg.cnt == `ACLK_HOST_RX_LAST && rx_tag[`ACLK_TAG_FRAME]) begin
                  if (rx_tag[`ACLK_TAG_CMD_ADDR]) begin
                     s_next.stat_idx = 7'(aclk_pkg::aclk_slot(rx_word, 1) >> 12);
                     s_next.stat_data = 16'(aclk_pkg::aclk_slot(rx_word, 2) >> 4);
                     s_next.stat_stb = 1'b1;
                  end
                  if (rx_tag[`ACLK_TAG_LEFT]) begin
                     s_next.rec_l = 18'(aclk_pkg::aclk_slot(rx_word, 3) >> 2);
                     s_next.rec_stb_l = 1'b1;
                  end
                  if (rx_tag[`ACLK_TAG_RIGHT]) begin
                     s_next.rec_r = 18'(aclk_pkg::aclk_slot(rx_word, 4) >> 2);
                     s_next.rec_stb_r = 1'b1;
                  end
               end
            end
            if (warm_req) begin
               s_next.st = aclk_pkg::aclk_h_warm;
               s_next.hold = 8'h00;
               s_next.mark = 1'b1;
            end
         end
         aclk_pkg::aclk_h_warm: begin
            // marker held high as warm reset, frames restart after
            s_next.mark = 1'b1;
            s_next.sdo = 1'b0;
            s_next.cnt = 8'h00;
            if (s_reg.hold == 8'(`ACLK_WARM_HOLD_CYC - 1)) begin
               s_next.hold = 8'h00;
               s_next.mark = 1'b0;
               s_next.st = aclk_pkg::aclk_h_run;
            end else begin
               s_next.hold = s_reg.hold + 8'h01;
            end
         end
         default: begin
            s_next.st = aclk_pkg::aclk_h_cold;
         end
      endcase

      // requests after frame load so a same-cycle take survives
      if (cmd_valid && cmd_ready) begin
         s_next.cmd_pend = 1'b1;
         s_next.cmd_rd = cmd_read;
         s_next.cmd_idx = cmd_index;
         s_next.cmd_wd = cmd_wdata;
      end
      if (play_valid && play_ready) begin
         s_next.play_pend = 1'b1;
         s_next.play_l = play_left;
         s_next.play_r = play_right;
      end

      if (cold_req) begin
         s_next.st = aclk_pkg::aclk_h_cold;
         s_next.hold = 8'h00;
         s_next.cold_n = 1'b0;
         s_next.cmd_pend = 1'b0;
         s_next.play_pend = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.st <= aclk_pkg::aclk_h_cold;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs
   assign link.cold_reset_n = s_reg.cold_n;
   assign link.frame_marker = s_reg.mark;
   assign link.host_to_codec_serial = s_reg.sdo;
   assign status_index = s_reg.stat_idx;
   assign status_data = s_reg.stat_data;
   assign status_strobe = s_reg.stat_stb;
   assign rec_left = s_reg.rec_l;
   assign rec_right = s_reg.rec_r;
   assign rec_strobe_left = s_reg.rec_stb_l;
   assign rec_strobe_right = s_reg.rec_stb_r;
   assign link_running = (s_reg.st == aclk_pkg::aclk_h_run);
endmodule
`default_nettype wire

// >>> sim/aclk_link_chk.sv
// assertions on the wires between codec end and host end
`timescale 1ns/10ps
`default_nettype none
module aclk_link_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic link_bit_clock,
   input wire logic codec_to_host_serial,
   input wire logic host_to_codec_serial,
   input wire logic frame_marker,
   input wire logic cold_reset_n
);
   logic [8:0] hi_reg;
   logic [7:0] lo_reg;
   logic [12:0] per_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n || !cold_reset_n);
   // restart in cold reset, else a reset pulse looks like a short frame
   always_ff @(posedge sys_clk) begin
      hi_reg <= (rst_n && frame_marker) ? hi_reg + 9'h001 : 9'h000;
      lo_reg <= (!rst_n || cold_reset_n) ? 8'h00 : lo_reg + 8'h01;
      if (!rst_n || !cold_reset_n) per_reg <= 13'h0000;
      else if ($rose(frame_marker)) per_reg <= 13'h0001;
      else if (per_reg != 13'h0000) per_reg <= per_reg + 13'h0001;
   end
   sequence bclk_high_s;
      link_bit_clock [*8] ##1 !link_bit_clock;
   endsequence
   a_bclk_half_period: assert property ($rose(link_bit_clock) |-> bclk_high_s)
      else $error("bit clock phase wrong");
   a_sdi_launch_high: assert property ($changed(codec_to_host_serial) |-> link_bit_clock)
      else $error("codec data moved in low phase");
   a_sdo_launch_high: assert property ($changed(host_to_codec_serial) |-> link_bit_clock)
      else $error("host data moved in low phase");
   a_marker_launch: assert property ($changed(frame_marker) |-> link_bit_clock)
      else $error("marker moved in low phase");
   a_marker_width: assert property ($fell(frame_marker) |-> hi_reg == 9'h100)
      else $error("marker width wrong");
   a_frame_period: assert property ($rose(frame_marker) && per_reg != 13'h0000 |-> per_reg == 13'h1000)
      else $error("frame period wrong");
   a_cold_hold: assert property (disable iff (!rst_n) $rose(cold_reset_n) |-> lo_reg >= 8'h14)
      else $error("cold reset too short");
   a_cold_clock_idle: assert property (disable iff (!rst_n) !cold_reset_n [*4] |-> !link_bit_clock)
      else $error("bit clock runs in cold reset");
   a_clock_starts: assert property ($rose(cold_reset_n) |-> ##[1:20] link_bit_clock)
      else $error("bit clock did not start");
endmodule
`default_nettype wire

// >>> sim/test_ac_link_codec_interface.sv
// bench joining codec end and host end over the link
`timescale 1ns/10ps
`default_nettype none
`include "aclk_defs.svh"
module test_ac_link_codec_interface;
   localparam int W = `ACLK_SAMPLE_W;
   logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cold_req = 1'b0, warm_req = 1'b0, strap = 1'b0;
   logic cmd_valid = 1'b0, cmd_read = 1'b0, play_valid = 1'b0;
   logic rec_valid_left = 1'b0, rec_valid_right = 1'b0;
   logic [6:0] cmd_index = 7'h00, idx, status_index;
   logic [15:0] cmd_wdata = 16'h0000, wd, status_data;
   logic [W-1:0] beep, pl, pr, rl, rr, line_l, line_r, hrl, hrr;
   logic cmd_ready, play_ready, status_strobe, hsl, hsr, link_running, play_strobe;
   logic test_ate, test_vendor, primary_codec;
   int num_errors = 0, checks_done = 0, seed = 32'h6de6f636, i;
   wire [5:0] sv = {play_ready, hsl, play_strobe, status_strobe, cmd_ready, link_running};
   aclk_link_if link ();
   aclk_codec_end u_aclk_codec_end (.sys_clk, .rst_n, .ce, .link, .codec_id_strap_high(strap),
      .codec_id_strap_low(strap), .beep_mono_input(beep), .rec_left(rl), .rec_right(rr),
      .rec_valid_left, .rec_valid_right, .line_out_left(line_l), .line_out_right(line_r),
      .play_strobe, .test_ate, .test_vendor, .link_powered_down(), .primary_codec);
   aclk_host_end u_aclk_host_end (.sys_clk, .rst_n, .ce, .link, .cold_req, .warm_req,
      .cmd_valid, .cmd_ready, .cmd_read, .cmd_index, .cmd_wdata, .play_valid, .play_ready,
      .play_left(pl), .play_right(pr), .status_index, .status_data, .status_strobe,
      .rec_left(hrl), .rec_right(hrr), .rec_strobe_left(hsl), .rec_strobe_right(hsr),
      .link_running);
   aclk_link_chk u_aclk_link_chk (.sys_clk, .rst_n, .link_bit_clock(link.link_bit_clock),
      .codec_to_host_serial(link.codec_to_host_serial), .frame_marker(link.frame_marker),
      .host_to_codec_serial(link.host_to_codec_serial), .cold_reset_n(link.cold_reset_n));
   initial forever #25 sys_clk = ~sys_clk;
   task summarize();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // bounded: a stuck handshake ends the run
   task automatic wait_on(input int w);
      int n;
      for (n = 0; n < 20000 && sv[w] !== 1'b1; n++) @(posedge sys_clk) #1;
      if (n == 20000) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic cmd(input logic rd, input logic [6:0] x, input logic [15:0] d);
      wait_on(1);
      {cmd_valid, cmd_read, cmd_index, cmd_wdata} = {1'b1, rd, x, d};
      @(posedge sys_clk) #1;
      cmd_valid = 1'b0;
   endtask
   initial begin
      {beep, pl, pr, rl, rr} = 90'({$random(seed), $random(seed), $random(seed)});
      repeat (2) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (10) @(posedge sys_clk) #1;
      check("beep left", line_l, beep);
      check("beep right", line_r, beep);
      check("clock in cold", W'(link.link_bit_clock), W'(0));
      wait_on(0);
      check("primary", W'(primary_codec), W'(1));
      $display("reset test done");
      for (i = 0; i < 3; i++) begin
         idx = (i == 0) ? 7'h0f : 7'(7 + ($unsigned($random(seed)) % 8));
         wd = (i == 0) ? 16'h0003 : 16'($random(seed));
         cmd(1'b0, idx, wd);
         cmd(1'b1, idx, 16'h0000);
         wait_on(2);
         check("status index", W'(status_index), W'(idx));
         check("status data", W'(status_data), W'(wd));
      end
      check("test modes on", W'({test_vendor, test_ate}), W'(2'h3));
      cold_req = 1'b1;
      @(posedge sys_clk) #1;
      cold_req = 1'b0;
      repeat (30) @(posedge sys_clk) #1;
      wait_on(0);
      check("test modes off", W'({test_vendor, test_ate}), W'(2'h0));
      cmd(1'b1, idx, 16'h0000);
      wait_on(2);
      check("reg default", W'(status_data), W'(16'h0000));
      $display("register test done");
      wait_on(5);
      play_valid = 1'b1;
      @(posedge sys_clk) #1;
      play_valid = 1'b0;
      wait_on(3);
      @(posedge sys_clk) #1;
      check("play left", line_l, pl);
      check("play right", line_r, pr);
      {rec_valid_left, rec_valid_right} = 2'h3;
      wait_on(4);
      check("rec left", hrl, rl);
      check("rec right", hrr, rr);
      check("rec strobe right", W'(hsr), W'(1));
      $display("stream test done");
      summarize();
   end
endmodule
`default_nettype wire
